/* File: rtl/txflags_pkg.sv */
package txflags_pkg;
  // ===========================================================
  // bus and data widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int CNT_W = 5;
  localparam int NFLAG = 3;

  // ===========================================================
  // register byte offsets
  localparam logic [7:0] OFS_PORT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FIFO_CONTROL = 8'h04;
  localparam logic [7:0] OFS_PORT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_TX_CONTROL_DATA = 8'h10;
  localparam logic [7:0] OFS_TX_DATA = 8'h14;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h18;

  // ===========================================================
  // field positions
  localparam int BIT_TX_ENABLE = 0;
  localparam int BIT_SOFT_RESET = 1;
  localparam int WM_LSB = 13;
  localparam int USABLE_LSB = 8;
  localparam int BIT_RESERVED = 15;
  localparam int FLAG_LSB = 12;
  localparam int IDX_REQ = 0;
  localparam int IDX_EMPTY = 1;
  localparam int IDX_READY = 2;

  // ===========================================================
  // reset values and counts
  localparam logic [2:0] WM_RESET = 3'h0;
  localparam logic [NFLAG-1:0] FLAGS_RESET = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  localparam logic [CNT_W-1:0] FIFO_STAGES = 5'h10;
  localparam logic [CNT_W-1:0] THR_ALL = 5'h10;
  localparam logic [CNT_W-1:0] THR_12 = 5'h0C;
  localparam logic [CNT_W-1:0] THR_8 = 5'h08;
  localparam logic [CNT_W-1:0] THR_4 = 5'h04;
  localparam logic [CNT_W-1:0] THR_1 = 5'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/reg_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface reg_if;
  import txflags_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_en;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_addr, rd_en,
    input wr_ok, rd_data, rd_ok
  );
  modport regs (
    input wr_en, wr_addr, wr_data, wr_strb, rd_addr, rd_en,
    output wr_ok, rd_data, rd_ok
  );
endinterface
`default_nettype wire

/* File: rtl/axil_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module axil_slave
  import txflags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  reg_if.bus rif
);
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [STRB_W-1:0] wstrb_r;

  // ===========================================================
  // write channel: address and data in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign rif.wr_en = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rif.wr_addr = awaddr_r;
  assign rif.wr_data = wdata_r;
  assign rif.wr_strb = wstrb_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (rif.wr_en) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= DATA_RESET;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (rif.wr_en) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (rif.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ===========================================================
  // read channel: decode is combinational, answer next cycle
  assign s_axi_arready = !s_axi_rvalid;
  assign rif.rd_en = s_axi_arvalid && s_axi_arready;
  assign rif.rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= DATA_RESET;
      s_axi_rresp <= RESP_OKAY;
    end else if (rif.rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rif.rd_data;
      s_axi_rresp <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/serial_port_tx_status_flags.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_port_tx_status_flags
  import txflags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CNT_W-1:0] tx_empty_stages,
  input wire logic ctrl_data_taken,
  output logic transmit_enable_bit,
  output logic [2:0] transmit_watermark_field,
  output logic tx_soft_reset,
  output logic tx_push,
  output logic [DATA_W-1:0] tx_push_data,
  output logic ctrl_data_valid,
  output logic [DATA_W-1:0] ctrl_data,
  output logic irq_control,
  output logic irq_transmit,
  output logic irq
);
  reg_if rif();

  axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.bus)
  );

  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wdata;
  logic [ADDR_W-3:0] wword;
  logic [ADDR_W-3:0] rword;
  logic wr_ctl;
  logic wr_fifo;
  logic wr_stat;
  logic wr_ien;
  logic wr_tcr;
  logic wr_tdr;
  logic wr_evt;
  logic clr;
  logic tx_en_r;
  logic push_in_flight;
  logic [2:0] wm_r;
  logic [NFLAG-1:0] ien_r;
  logic [NFLAG-1:0] flag_r;
  logic [NFLAG-1:0] flag_nxt;
  logic [NFLAG-1:0] vis;
  logic [NFLAG-1:0] evt_r;
  logic [NFLAG-1:0] evt_nxt;
  logic [CNT_W-1:0] thr;
  logic [15:0] status_word;
  logic [15:0] fifo_word;

  // ===========================================================
  // write decode
  assign wdata = rif.wr_data;
  assign wword = rif.wr_addr[ADDR_W-1:2];
  assign rword = rif.rd_addr[ADDR_W-1:2];
  assign wr_ctl = rif.wr_en && (wword == OFS_PORT_CONTROL[ADDR_W-1:2]);
  assign wr_fifo = rif.wr_en && (wword == OFS_FIFO_CONTROL[ADDR_W-1:2]);
  assign wr_stat = rif.wr_en && (wword == OFS_PORT_STATUS[ADDR_W-1:2]);
  assign wr_ien = rif.wr_en && (wword == OFS_INT_ENABLE[ADDR_W-1:2]);
  assign wr_tcr = rif.wr_en && (wword == OFS_TX_CONTROL_DATA[ADDR_W-1:2]);
  assign wr_tdr = rif.wr_en && (wword == OFS_TX_DATA[ADDR_W-1:2]);
  assign wr_evt = rif.wr_en && (wword == OFS_EVENT_STATUS[ADDR_W-1:2]);
  // status writes are accepted but change nothing
  assign rif.wr_ok = wr_ctl | wr_fifo | wr_stat | wr_ien | wr_tcr | wr_tdr | wr_evt;

  for (genvar i = 0; i < STRB_W; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{rif.wr_strb[i]}};
  end

  // ===========================================================
  // control and configuration
  assign tx_soft_reset = wr_ctl && wmask[BIT_SOFT_RESET] && wdata[BIT_SOFT_RESET];
  // soft reset spares enable, watermark and masks so software need not reload them
  assign clr = !aresetn || tx_soft_reset;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en_r <= 1'b0;
    end else if (wr_ctl && wmask[BIT_TX_ENABLE]) begin
      tx_en_r <= wdata[BIT_TX_ENABLE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wm_r <= WM_RESET;
    end else if (wr_fifo && wmask[WM_LSB]) begin
      wm_r <= wdata[WM_LSB +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_r <= FLAGS_RESET;
    end else if (wr_ien && wmask[FLAG_LSB]) begin
      ien_r <= wdata[FLAG_LSB +: NFLAG];
    end
  end

  assign transmit_enable_bit = tx_en_r;
  assign transmit_watermark_field = wm_r;

  // ===========================================================
  // watermark threshold; reserved codes fall back to all-empty
  always_comb begin
    unique case (wm_r)
      3'h0: thr = THR_ALL;
      3'h4: thr = THR_12;
      3'h5: thr = THR_8;
      3'h6: thr = THR_4;
      3'h7: thr = THR_1;
      default: thr = THR_ALL;
    endcase
  end

  // ===========================================================
  // transmit flags
  assign push_in_flight = tx_push;

  always_comb begin
    flag_nxt = flag_r;
    // request follows the empty count both ways
    flag_nxt[IDX_REQ] = (tx_empty_stages >= thr);
    // the empty count lags the write by two edges; keep the flag low meanwhile
    if (wr_tdr || push_in_flight) begin
      flag_nxt[IDX_EMPTY] = 1'b0;
    end else begin
      flag_nxt[IDX_EMPTY] = (tx_empty_stages == FIFO_STAGES);
    end
    // a take in the same cycle as a write still marks room
    if (ctrl_data_taken) begin
      flag_nxt[IDX_READY] = 1'b1;
    end else if (wr_tcr) begin
      flag_nxt[IDX_READY] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      flag_r <= FLAGS_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // flags mean nothing while the transmitter is off
  assign vis = flag_r & {NFLAG{tx_en_r}};

  assign status_word = {1'b0, vis, 12'h000};
  assign fifo_word = {wm_r, tx_empty_stages, 8'h00};

  // ===========================================================
  // control data holding register
  always_ff @(posedge aclk) begin
    if (clr) begin
      ctrl_data <= DATA_RESET;
    end else if (wr_tcr) begin
      // an unsent value is simply replaced
      ctrl_data <= (ctrl_data & ~wmask) | (wdata & wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      ctrl_data_valid <= 1'b0;
    end else if (wr_tcr) begin
      ctrl_data_valid <= 1'b1;
    end else if (ctrl_data_taken) begin
      ctrl_data_valid <= 1'b0;
    end
  end

  // ===========================================================
  // transmit data push toward the FIFO
  always_ff @(posedge aclk) begin
    if (clr) begin
      tx_push <= 1'b0;
    end else begin
      tx_push <= wr_tdr;
    end
  end

  // the word is whole wdata; byte strobes do not apply to the fifo
  always_ff @(posedge aclk) begin
    if (clr) begin
      tx_push_data <= DATA_RESET;
    end else if (wr_tdr) begin
      tx_push_data <= wdata;
    end
  end

  // ===========================================================
  // sticky events, write one to clear; a new event beats the clear
  for (genvar i = 0; i < NFLAG; i++) begin : g_evt
    always_comb begin
      evt_nxt[i] = evt_r[i];
      if (vis[i]) begin
        evt_nxt[i] = 1'b1;
      end else if (wr_evt && wmask[FLAG_LSB + i] && wdata[FLAG_LSB + i]) begin
        evt_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      evt_r <= FLAGS_RESET;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // ===========================================================
  // interrupt outputs
  always_ff @(posedge aclk) begin
    if (clr) begin
      irq_control <= 1'b0;
    end else begin
      irq_control <= |(evt_r[IDX_READY:IDX_EMPTY] & ien_r[IDX_READY:IDX_EMPTY]);
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      irq_transmit <= 1'b0;
    end else begin
      irq_transmit <= evt_r[IDX_REQ] & ien_r[IDX_REQ];
    end
  end

  assign irq = irq_control | irq_transmit;

  // ===========================================================
  // read decode; unmapped offsets answer with an error
  always_comb begin
    rif.rd_data = DATA_RESET;
    rif.rd_ok = 1'b1;
    unique case (rword)
      OFS_PORT_CONTROL[ADDR_W-1:2]: begin
        rif.rd_data[BIT_TX_ENABLE] = tx_en_r;
      end
      OFS_FIFO_CONTROL[ADDR_W-1:2]: begin
        rif.rd_data[15:0] = fifo_word;
      end
      OFS_PORT_STATUS[ADDR_W-1:2]: begin
        rif.rd_data[15:0] = status_word;
      end
      OFS_INT_ENABLE[ADDR_W-1:2]: begin
        rif.rd_data[FLAG_LSB +: NFLAG] = ien_r;
      end
      OFS_TX_CONTROL_DATA[ADDR_W-1:2]: begin
        rif.rd_data = ctrl_data;
      end
      OFS_TX_DATA[ADDR_W-1:2]: begin
        rif.rd_data = DATA_RESET;
      end
      OFS_EVENT_STATUS[ADDR_W-1:2]: begin
        rif.rd_data[FLAG_LSB +: NFLAG] = evt_r;
      end
      default: begin
        rif.rd_ok = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: sim/tx_flags_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module tx_flags_checker
  import txflags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_wvalid,
  input wire logic ctrl_data_taken,
  input wire logic transmit_enable_bit,
  input wire logic tx_soft_reset,
  input wire logic tx_push,
  input wire logic ctrl_data_valid,
  input wire logic irq
);
  // ==========
  // address of the read in flight
  logic [ADDR_W-1:0] rd_addr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_r <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_r <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // properties
  a_hw_reset_quiet: assert property (
    disable iff (1'b0) !aresetn |=> !irq && !ctrl_data_valid && !tx_push)
    else $error("outputs active after reset");
  a_soft_reset_quiet: assert property (tx_soft_reset |=> !irq && !ctrl_data_valid)
    else $error("soft reset left state");
  a_ctrl_data_held: assert property (
    ctrl_data_valid && !ctrl_data_taken && !tx_soft_reset |=> ctrl_data_valid)
    else $error("control data lost untaken");
  // a write landing beside the take would legally refill the holding register
  a_taken_drops_valid: assert property (
    ctrl_data_taken && !s_axi_wvalid && !$past(s_axi_wvalid) |=> !ctrl_data_valid)
    else $error("control data valid after take");
  a_push_one_cycle: assert property (tx_push |=> !tx_push)
    else $error("push longer than a cycle");
  a_status_reserved_zero: assert property (
    s_axi_rvalid && rd_addr_r == OFS_PORT_STATUS |-> s_axi_rdata[15] == 1'b0)
    else $error("reserved status bit set");
  a_status_txe_gated: assert property (
    $rose(s_axi_rvalid) && rd_addr_r == OFS_PORT_STATUS && !$past(transmit_enable_bit)
    |-> s_axi_rdata[14:12] == 3'h0)
    else $error("flags shown while disabled");
  a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind serial_port_tx_status_flags tx_flags_checker i_tx_flags_checker (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_wvalid, .ctrl_data_taken, .transmit_enable_bit,
  .tx_soft_reset, .tx_push, .ctrl_data_valid, .irq
);
`default_nettype wire

/* File: sim/tx_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module tx_far_end
  import txflags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_push,
  input wire logic tx_soft_reset,
  input wire logic drain,
  input wire logic take_en,
  input wire logic ctrl_data_valid,
  input wire logic [DATA_W-1:0] ctrl_data,
  output logic [CNT_W-1:0] tx_empty_stages,
  output logic ctrl_data_taken,
  output logic [DATA_W-1:0] sent_ctrl
);
  // ==========
  // sixteen-stage fifo occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_soft_reset) begin
      tx_empty_stages <= FIFO_STAGES;
    end else if (tx_push && !drain && tx_empty_stages != 5'h00) begin
      tx_empty_stages <= tx_empty_stages - 5'h01;
    end else if (drain && !tx_push && tx_empty_stages != FIFO_STAGES) begin
      tx_empty_stages <= tx_empty_stages + 5'h01;
    end
  end
  // ==========
  // shifter: one take per word, only when allowed, so a stall can be forced
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_soft_reset) begin
      ctrl_data_taken <= 1'b0;
    end else begin
      ctrl_data_taken <= take_en && ctrl_data_valid && !ctrl_data_taken;
    end
    if (take_en && ctrl_data_valid && !ctrl_data_taken) begin
      sent_ctrl <= ctrl_data;
    end
  end
endmodule
`default_nettype wire

/* File: sim/serial_port_tx_status_flags_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_port_tx_status_flags_tb;
  import txflags_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, drain, take_en, ctrl_data_taken, transmit_enable_bit;
  logic tx_soft_reset, tx_push, ctrl_data_valid, irq_control, irq_transmit, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, tx_push_data, ctrl_data, sent_ctrl;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [CNT_W-1:0] tx_empty_stages;
  logic [2:0] transmit_watermark_field;
  logic [33:0] rexp[$];
  logic [1:0] bexp[$];
  logic [2:0] codes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  int thr [5] = '{16, 12, 8, 4, 1};
  int miscompares, checks;
  serial_port_tx_status_flags i_serial_port_tx_status_flags (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_empty_stages, .ctrl_data_taken,
    .transmit_enable_bit, .transmit_watermark_field, .tx_soft_reset, .tx_push,
    .tx_push_data, .ctrl_data_valid, .ctrl_data, .irq_control, .irq_transmit, .irq
  );
  tx_far_end i_tx_far_end (.aclk, .aresetn, .tx_push, .tx_soft_reset, .drain, .take_en,
    .ctrl_data_valid, .ctrl_data, .tx_empty_stages, .ctrl_data_taken, .sent_ctrl);
  // ==========
  // reporting
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic time_out();
    miscompares++;
    tally_and_finish();
  endtask
  task automatic irqs_are(input logic [2:0] e);
    check({31'h0, irq_control, irq_transmit, irq}, {31'h0, e});
  endtask
  // ==========
  // bus master: handshakes judged at the falling edge, acted on after the rising one
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e = RESP_OKAY);
    int n;
    logic aw_hs, w_hs, ar_hs, done;
    if (rd) begin
      rexp.push_back({e, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end else begin
      bexp.push_back(e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    n = 0;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      ar_hs = s_axi_arvalid && s_axi_arready;
      done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
      n++;
      if (n > 100) time_out();
    end
    // flag, event and interrupt each take one more edge
    // a read lets one edge pass so rready is never raised again in the same step
    repeat (rd ? 1 : 4) @(posedge aclk);
  endtask
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rexp.size() > 0)
      check({s_axi_rresp, s_axi_rdata}, rexp.pop_front());
    if (s_axi_bvalid && s_axi_bready && bexp.size() > 0)
      check({32'h00000000, s_axi_bresp}, {32'h00000000, bexp.pop_front()});
  end
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ==========
  // scenarios
  initial begin
    int n;
    logic [31:0] a_word, b_word;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, drain, take_en} = 6'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    miscompares = 0;
    checks = 0;
    void'($urandom(66049));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    xfer(1'b1, OFS_PORT_STATUS, 32'h00000000);
    xfer(1'b1, OFS_FIFO_CONTROL, 32'h00001000);
    xfer(1'b1, 8'h1C, 32'h00000000, RESP_SLVERR);
    xfer(1'b0, 8'h1C, $urandom, RESP_SLVERR);
    xfer(1'b0, OFS_PORT_CONTROL, 32'h00000001);
    check({33'h0, transmit_enable_bit}, {33'h0, 1'b1});
    xfer(1'b1, OFS_PORT_STATUS, 32'h00003000);
    xfer(1'b0, OFS_PORT_STATUS, $urandom & 32'h00007FFF);
    xfer(1'b1, OFS_PORT_STATUS, 32'h00003000);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, OFS_FIFO_CONTROL, {16'h0000, codes[i], 13'h0000});
      check({31'h0, transmit_watermark_field}, {31'h0, codes[i]});
      xfer(1'b0, OFS_PORT_CONTROL, 32'h00000003);
      for (int k = 0; k < 16 - thr[i]; k++) xfer(1'b0, OFS_TX_DATA, $urandom);
      xfer(1'b1, OFS_PORT_STATUS, thr[i] == 16 ? 32'h00003000 : 32'h00001000);
      a_word = $urandom;
      xfer(1'b0, OFS_TX_DATA, a_word);
      check({2'h0, tx_push_data}, {2'h0, a_word});
      xfer(1'b1, OFS_PORT_STATUS, 32'h00000000);
    end
    drain <= 1'b1;
    n = 0;
    while (tx_empty_stages !== FIFO_STAGES) begin
      @(negedge aclk);
      n++;
      if (n > 40) time_out();
    end
    @(posedge aclk);
    drain <= 1'b0;
    repeat (2) @(posedge aclk);
    xfer(1'b1, OFS_PORT_STATUS, 32'h00003000);
    xfer(1'b0, OFS_PORT_CONTROL, 32'h00000000);
    check({33'h0, transmit_enable_bit}, 34'h0);
    xfer(1'b1, OFS_PORT_STATUS, 32'h00000000);
    xfer(1'b0, OFS_PORT_CONTROL, 32'h00000001);
    irqs_are(3'h0);
    xfer(1'b0, OFS_INT_ENABLE, 32'h00002000);
    irqs_are(3'h5);
    xfer(1'b0, OFS_INT_ENABLE, 32'h00001000);
    irqs_are(3'h3);
    xfer(1'b1, OFS_EVENT_STATUS, 32'h00003000);
    xfer(1'b0, OFS_FIFO_CONTROL, 32'h00000000);
    xfer(1'b0, OFS_TX_DATA, $urandom);
    xfer(1'b0, OFS_EVENT_STATUS, 32'h00007000);
    xfer(1'b1, OFS_EVENT_STATUS, 32'h00000000);
    irqs_are(3'h0);
    a_word = $urandom;
    b_word = $urandom;
    xfer(1'b0, OFS_INT_ENABLE, 32'h00004000);
    xfer(1'b0, OFS_TX_CONTROL_DATA, a_word);
    xfer(1'b0, OFS_TX_CONTROL_DATA, b_word);
    xfer(1'b1, OFS_TX_CONTROL_DATA, b_word);
    xfer(1'b1, OFS_PORT_STATUS, 32'h00000000);
    take_en <= 1'b1;
    n = 0;
    while (ctrl_data_taken !== 1'b1) begin
      @(negedge aclk);
      n++;
      if (n > 40) time_out();
    end
    @(posedge aclk);
    take_en <= 1'b0;
    repeat (4) @(posedge aclk);
    check({2'h0, sent_ctrl}, {2'h0, b_word});
    xfer(1'b1, OFS_PORT_STATUS, 32'h00004000);
    irqs_are(3'h5);
    xfer(1'b0, OFS_TX_CONTROL_DATA, a_word);
    xfer(1'b1, OFS_PORT_STATUS, 32'h00000000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    xfer(1'b1, OFS_INT_ENABLE, 32'h00000000);
    xfer(1'b1, OFS_EVENT_STATUS, 32'h00000000);
    irqs_are(3'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
